// >>> dv/spe_monitor.sv
`timescale 1ns/1ps
module spe_monitor (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic MASTER_CLEAR_PIN,
  input wire logic MASTER_CLEAR_HV,
  input wire logic LOW_VOLTAGE_ENTRY_ENABLE,
  input wire logic PROG_SERIAL_DATA_OE,
  input wire logic PROG_VERIFY_MODE,
  input wire logic HV_SESSION,
  input wire logic LV_SESSION,
  input wire logic MASTER_CLEAR_RESET_ENABLE,
  input wire logic LVE_CLEAR_GRANT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_oe_in_mode: assert property (PROG_SERIAL_DATA_OE |-> PROG_VERIFY_MODE) else $error("oe");
  chk_mode_kind: assert property (PROG_VERIFY_MODE == (HV_SESSION | LV_SESSION)) else $error("md");
  chk_hv_entry: assert property ($rose(MASTER_CLEAR_HV) |-> ##[1:6] HV_SESSION) else $error("hv");
  chk_hv_exit: assert property (!MASTER_CLEAR_HV [*6] |-> !HV_SESSION) else $error("hx");
  chk_lv_gate: assert property (!LOW_VOLTAGE_ENTRY_ENABLE [*6] |-> !LV_SESSION) else $error("lg");
  chk_lv_hold: assert property (MASTER_CLEAR_PIN [*6] |-> !LV_SESSION) else $error("lh");
  chk_master_clear_pin_forced: assert property (LOW_VOLTAGE_ENTRY_ENABLE [*6] |-> MASTER_CLEAR_RESET_ENABLE)
    else $error("mf");
  chk_clear_hv: assert property (LVE_CLEAR_GRANT |-> HV_SESSION) else $error("cg");
  cover property ($rose(HV_SESSION));
  cover property ($rose(LV_SESSION));
  cover property (LVE_CLEAR_GRANT);
endmodule
bind spe_entry spe_monitor i_mon (.*);

// >>> dv/spe_prog.sv
`timescale 1ns/1ps
module spe_prog (
  output logic sck,
  output logic sdat,
  output logic mclear,
  output logic hv
);
  initial {sck, sdat, mclear, hv} = 4'h2;
  // The clock stands still between frames; an odd start keeps it off the core clock phase.
  task send(input logic [31:0] k);
    #3;
    for (int i = 31; i >= 0; i--) begin
      sdat = k[i];
      #8 sck = 1;
      #16 sck = 0;
      #8;
    end
    sdat = ~sdat;
  endtask
  task hv_set(input logic v);
    sck = 0;
    sdat = 0;
    #40 hv = v;
  endtask
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, lve = 0, cfg = 0, oreq = 0, oval = 0, creq = 0;
  logic dout, oe, pvm, we, hvs, lvs, mcre, grant;
  wire  sck, pdat, mclear, hv;
  wire  sdi = oe ? dout : pdat;
  int   failures = 0, comparisons = 0, cyc = 0;
  always #4 clk = ~clk;
  spe_prog i_prog (.sck(sck), .sdat(pdat), .mclear(mclear), .hv(hv));
  spe_entry i_dut (.CLK(clk), .RESET(rst), .PROG_SERIAL_CLOCK(sck),
    .PROG_SERIAL_DATA_IN(sdi), .MASTER_CLEAR_PIN(mclear), .MASTER_CLEAR_HV(hv),
    .LOW_VOLTAGE_ENTRY_ENABLE(lve), .MASTER_CLEAR_CFG_RESET_ENABLE(cfg),
    .PROG_DATA_OUT_REQ(oreq),
    .PROG_DATA_OUT_VALUE(oval), .LVE_CLEAR_REQ(creq), .PROG_SERIAL_DATA_OUT(dout),
    .PROG_SERIAL_DATA_OE(oe), .PROG_VERIFY_MODE(pvm), .PROG_WRITE_ENABLE(we),
    .HV_SESSION(hvs), .LV_SESSION(lvs), .MASTER_CLEAR_RESET_ENABLE(mcre),
    .LVE_CLEAR_GRANT(grant));
  task chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %h %h", $time, got, exp);
    end
  endtask
  task wrap_up();
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task settle();
    repeat (8) @(negedge clk);
  endtask
  task t_lv(input logic en, input logic [31:0] k, input logic exp);
    lve = en;
    i_prog.mclear = 0;
    i_prog.send(k);
    settle();
    chk(lvs, exp);
    chk(mcre, en);
    cfg = 1;
    settle();
    chk(mcre, 1);
    cfg = 0;
    creq = 1;
    settle();
    chk(grant, 0);
    creq = 0;
    i_prog.mclear = 1;
    settle();
    chk(lvs, 0);
  endtask
  task t_hv();
    lve = 1;
    i_prog.hv_set(1);
    settle();
    chk(hvs, 1);
    chk(we, 1);
    chk(pvm, 1);
    oreq = 1;
    oval = 1;
    creq = 1;
    settle();
    chk(sdi, 1);
    chk(grant, 1);
    oreq = 0;
    creq = 0;
    i_prog.hv_set(0);
    settle();
    chk(pvm, 0);
    chk(hvs, 0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    settle();
    t_lv(1, spe_pkg::SPE_KEY_DEFAULT, 1);
    t_lv(1, spe_pkg::SPE_KEY_DEFAULT ^ 32'h00000001, 0);
    t_lv(0, spe_pkg::SPE_KEY_DEFAULT, 0);
    t_hv();
    wrap_up();
  end
endmodule

// >>> verilog/spe_entry.sv
`timescale 1ns/1ps
// Notes on behaviour
// - The data pin is two-way and the serial clock is only an input driven by the programmer.
// - In Program/Verify mode the port grants programming of memory, user IDs and configuration.
// - With clock and data low, a rise of master clear to programming level enters the mode.
// - Key entry is recognised only while the low-voltage entry enable bit reads one.
// - With master clear low, a 32-bit key is shifted in on the data pin, one bit per clock.
// - After a correct key the mode holds only while master clear stays low.
// - While low-voltage entry is enabled, the master clear reset function is forced on.
// - Clearing the low-voltage entry enable bit is allowed only in a high-voltage session.
module spe_entry
  import spe_pkg::*;
#(
  parameter logic [31:0] KEY = SPE_KEY_DEFAULT
) (
  input  wire logic CLK,
  input  wire logic RESET,
  input  wire logic PROG_SERIAL_CLOCK,
  input  wire logic PROG_SERIAL_DATA_IN,
  input  wire logic MASTER_CLEAR_PIN,
  input  wire logic MASTER_CLEAR_HV,
  input  wire logic LOW_VOLTAGE_ENTRY_ENABLE,
  input  wire logic MASTER_CLEAR_CFG_RESET_ENABLE,
  input  wire logic PROG_DATA_OUT_REQ,
  input  wire logic PROG_DATA_OUT_VALUE,
  input  wire logic LVE_CLEAR_REQ,
  output logic      PROG_SERIAL_DATA_OUT,
  output logic      PROG_SERIAL_DATA_OE,
  output logic      PROG_VERIFY_MODE,
  output logic      PROG_WRITE_ENABLE,
  output logic      HV_SESSION,
  output logic      LV_SESSION,
  output logic      MASTER_CLEAR_RESET_ENABLE,
  output logic      LVE_CLEAR_GRANT
);
  spe_mode_t   mode;
  spe_mode_t   next_mode;
  logic        mclear_s;
  logic        hv_s;
  logic        lve_s;
  logic        sclk_s;
  logic        sdat_s;
  logic        hv_prev;
  logic        key_ok_s;
  logic        key_ok_prev;
  logic        link_arm;
  // Link domain state, clocked by the programmer's serial clock.
  logic [31:0] shift;
  logic [5:0]  count;
  logic        key_ok;

  // Any session counts; the mode outputs and the pin driver share this decode.
  function automatic logic in_session(input spe_mode_t m);
    return m != SPE_OFF;
  endfunction

  // Level crossings into the system domain.
  spe_sync u_mclear (
    .clk (CLK),
    .rst (RESET),
    .d   (MASTER_CLEAR_PIN),
    .q   (mclear_s)
  );

  spe_sync u_hv (
    .clk (CLK),
    .rst (RESET),
    .d   (MASTER_CLEAR_HV),
    .q   (hv_s)
  );

  spe_sync u_lve (
    .clk (CLK),
    .rst (RESET),
    .d   (LOW_VOLTAGE_ENTRY_ENABLE),
    .q   (lve_s)
  );

  spe_sync u_sclk (
    .clk (CLK),
    .rst (RESET),
    .d   (PROG_SERIAL_CLOCK),
    .q   (sclk_s)
  );

  spe_sync u_sdat (
    .clk (CLK),
    .rst (RESET),
    .d   (PROG_SERIAL_DATA_IN),
    .q   (sdat_s)
  );

  // The key result is a level that holds while the link clock stands still.
  spe_sync u_kok (
    .clk (CLK),
    .rst (RESET),
    .d   (key_ok),
    .q   (key_ok_s)
  );

  // The link clock stops outside a key, so the key logic is held clear by the level
  // of master clear and the enable pin themselves rather than by a clock edge.
  assign link_arm = LOW_VOLTAGE_ENTRY_ENABLE & ~MASTER_CLEAR_PIN & ~MASTER_CLEAR_HV;

  always_ff @(posedge PROG_SERIAL_CLOCK or negedge link_arm) begin
    if (!link_arm) begin
      shift <= SPE_SHIFT_ZERO;
      count <= SPE_CNT_ZERO;
    end else if (count != SPE_CNT_FULL) begin
      shift <= {shift[SPE_KEY_BITS-2:0], PROG_SERIAL_DATA_IN};
      count <= count + 6'h01;
    end
  end

  // Clocks past the last key bit leave the verdict alone; only dropping link_arm clears it.
  always_ff @(posedge PROG_SERIAL_CLOCK or negedge link_arm) begin
    if (!link_arm) begin
      key_ok <= 1'b0;
    end else if (count == SPE_CNT_FULL - 6'h01) begin
      key_ok <= {shift[SPE_KEY_BITS-2:0], PROG_SERIAL_DATA_IN} == KEY;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      hv_prev <= 1'b0;
    end else begin
      hv_prev <= hv_s;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      key_ok_prev <= 1'b0;
    end else begin
      key_ok_prev <= key_ok_s;
    end
  end

  always_comb begin
    next_mode = mode;
    unique case (mode)
      SPE_OFF: begin
        if (hv_s && !hv_prev && !sclk_s && !sdat_s) begin
          next_mode = SPE_HV_SESS;
        end else if (lve_s && !mclear_s && !hv_s && key_ok_s && !key_ok_prev) begin
          next_mode = SPE_LV_SESS;
        end
      end
      SPE_HV_SESS: begin
        if (!hv_s) begin
          next_mode = SPE_OFF;
        end
      end
      SPE_LV_SESS: begin
        if (mclear_s || hv_s || !key_ok_s) begin
          next_mode = SPE_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mode <= SPE_OFF;
    end else begin
      mode <= next_mode;
    end
  end

  // Outputs follow next_mode so they line up with the state register edge.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PROG_VERIFY_MODE  <= 1'b0;
      PROG_WRITE_ENABLE <= 1'b0;
    end else begin
      PROG_VERIFY_MODE  <= in_session(next_mode);
      PROG_WRITE_ENABLE <= in_session(next_mode);
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      HV_SESSION <= 1'b0;
      LV_SESSION <= 1'b0;
    end else begin
      HV_SESSION <= next_mode == SPE_HV_SESS;
      LV_SESSION <= next_mode == SPE_LV_SESS;
    end
  end

  // A key-entered session can never clear the enable bit, or it could lock itself out.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      LVE_CLEAR_GRANT <= 1'b0;
    end else begin
      LVE_CLEAR_GRANT <= LVE_CLEAR_REQ && next_mode == SPE_HV_SESS;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      MASTER_CLEAR_RESET_ENABLE <= 1'b1;
    end else begin
      MASTER_CLEAR_RESET_ENABLE <= lve_s | MASTER_CLEAR_CFG_RESET_ENABLE;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PROG_SERIAL_DATA_OUT <= 1'b0;
    end else begin
      PROG_SERIAL_DATA_OUT <= PROG_DATA_OUT_VALUE;
    end
  end

  // Drive the data pin only during a session and only when the core asks to read back.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PROG_SERIAL_DATA_OE <= 1'b0;
    end else begin
      PROG_SERIAL_DATA_OE <= PROG_DATA_OUT_REQ && in_session(next_mode);
    end
  end
endmodule

// >>> verilog/spe_pkg.sv
package spe_pkg;
  // Key width in bits; the key value itself is a top-level parameter.
  localparam int          SPE_KEY_BITS    = 32;
  // Default key value is arbitrary; a real part sets its own through the KEY parameter.
  localparam logic [31:0] SPE_KEY_DEFAULT = 32'h5a3c96a5;
  localparam logic [5:0]  SPE_CNT_ZERO    = 6'h00;
  localparam logic [5:0]  SPE_CNT_FULL    = 6'h20;
  localparam logic [31:0] SPE_SHIFT_ZERO  = 32'h00000000;

  typedef enum logic [2:0] {
    SPE_OFF     = 3'b001,
    SPE_HV_SESS = 3'b010,
    SPE_LV_SESS = 3'b100
  } spe_mode_t;
endpackage

// >>> verilog/spe_sync.sv
`timescale 1ns/1ps
module spe_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
